// >>> hdl/hpd_defrost_board.sv
// defrost board controller: compressors, valves, fan delay, defrost timing
// Function
// - run period selectable as 30, 60, 90 or 120 minutes
// - default switch setting gives a 60 minute run period
// - no defrost inside the run period; it restarts after defrost or a factory test short
// - at expiry with frost switch open, restart a full run period
// - at expiry with frost switch closed, enter defrost
// - defrost ends on frost switch opening or after 10 minutes
// - after defrost, return to heating with a fresh run period
// - elapsed run count held when heating stops, resumed on restart
// - both valves on in cooling, off in heating, no position input
// - valves keep their last state until the opposite mode starts
// - cooling runs one compressor, heating runs both
// - fan-delay switch open keeps fan on 30 s after demand ends
// - fan delay starts when cool or heat demand is removed
// - short of 1 to 3 s scales timers to 0.1 s per minute
// - scaled mode runs one heat and one defrost cycle, then ends
// - factory test defrost lasts at most 12 seconds
// - short of 5 to 20 s skips the run period into forced defrost
// - forced defrost with switch closed is a normal defrost
// - forced defrost with switch open runs exactly 30 seconds
// - each speed-up mode ends when its defrost cycle finishes
//
// Implementation choices: register access over AHB-Lite and the register addresses.
module hpd_defrost_board
    import hpd_pkg::*;
#(
    parameter int unsigned TICK_CYC = hpd_pkg::TICK_CYCLES
) (
    // clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // demands, switches and jumpers
    input  wire logic        cool_call_stage1,
    input  wire logic        heat_call_stage1,
    input  wire logic        coil_frost_switch,
    input  wire logic        run_period_select_lo,
    input  wire logic        run_period_select_hi,
    input  wire logic        fan_delay_select,
    input  wire logic        speedup_contact_a,
    input  wire logic        speedup_contact_b,
    // driver commands
    output logic             reversing_valve_one,
    output logic             reversing_valve_two,
    output logic             comp_one_cmd,
    output logic             comp_two_cmd,
    output logic             indoor_fan_cmd
);
    import hpd_pkg::*;

    localparam logic [SHORT_W-1:0] SHORT_MAX = '1;

    typedef struct packed {
        hpd_state_type      state;
        logic [CNT_W-1:0]   run_cnt;
        logic [CNT_W-1:0]   def_cnt;
        logic [CNT_W-1:0]   fan_cnt;
        logic [SHORT_W-1:0] short_cnt;
        logic               scaled;
        logic               forced;
        logic               forced_open;
        logic               rv1;
        logic               rv2;
        logic               comp1;
        logic               comp2;
        logic               fan;
        logic               enable;
        logic               wr_pend;
        logic [7:0]         wr_addr;
        logic [31:0]        rdata;
        logic               ready;
        logic               resp;   // held low: every transfer answers okay
    } hpd_regs_type;

    hpd_regs_type st;
    hpd_regs_type next_st;

    logic [7:0]       pins;
    logic             tick;
    logic             cool;
    logic             heat;
    logic             frost;
    logic             fan_sel;
    logic             shorted;
    logic [1:0]       run_sel;
    logic [CNT_W-1:0] per_min;
    logic [CNT_W-1:0] run_target;
    logic [CNT_W-1:0] def_limit;
    logic             ft_req;
    logic             fd_req;
    logic             def_end;
    logic [31:0]      status_word;

    // every demand, switch and jumper pin passes two flops before use
    hpd_sync #(.WIDTH(8)) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ce       (ce),
        .async_in ({cool_call_stage1, heat_call_stage1, coil_frost_switch,
                    run_period_select_lo, run_period_select_hi, fan_delay_select,
                    speedup_contact_a, speedup_contact_b}),
        .sync_out (pins)
    );

    hpd_tick #(.CYCLES(TICK_CYC)) u_tick (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .tick    (tick)
    );

    assign cool    = pins[7];
    assign heat    = pins[6];
    assign frost   = pins[5];                 // high: switch closed
    assign run_sel = {pins[3], pins[4]};
    assign fan_sel = pins[2];                 // high: delay disabled
    assign shorted = pins[1] & pins[0];

    // period selection and scaling
    always_comb begin
        per_min = st.scaled ? CNT_W'(SCALED_TPM) : CNT_W'(TICKS_PER_MIN);
        case (run_sel)
            2'h0:    run_target = CNT_W'(RUN_MIN_0 * per_min);
            2'h1:    run_target = CNT_W'(RUN_MIN_1 * per_min);
            2'h2:    run_target = CNT_W'(RUN_MIN_2 * per_min);
            default: run_target = CNT_W'(RUN_MIN_3 * per_min);
        endcase
        def_limit = st.forced_open ? CNT_W'(FORCED_TICKS)
                                   : CNT_W'(DEFROST_MIN * per_min);
    end

    // a short is judged when the contacts open again; others are dropped
    always_comb begin
        ft_req = !shorted && (st.short_cnt >= SHORT_W'(FT_MIN_S * TICKS_PER_SEC))
                 && (st.short_cnt <= SHORT_W'(FT_MAX_S * TICKS_PER_SEC));
        fd_req = !shorted && (st.short_cnt >= SHORT_W'(FD_MIN_S * TICKS_PER_SEC))
                 && (st.short_cnt <= SHORT_W'(FD_MAX_S * TICKS_PER_SEC));
        def_end = (!st.forced_open && !frost)
                  || (tick && (st.def_cnt + 1'b1 >= def_limit));
    end

    assign status_word = 32'({st.state, st.scaled, st.forced, st.forced_open,
                              st.rv1, st.rv2, st.comp1, st.comp2, st.fan, frost});

    // whole next-state: sequencer, outputs and bus slave
    always_comb begin
        next_st = st;
        if (ce) begin
            // contact short timer, saturating so a long short stays out of range
            if (shorted) begin
                if (tick && st.short_cnt != SHORT_MAX) begin
                    next_st.short_cnt = st.short_cnt + 1'b1;
                end
            end else begin
                next_st.short_cnt = '0;
            end

            case (st.state)
                ST_IDLE: begin
                    if (st.enable && cool) begin
                        next_st.state = ST_COOL;
                    end else if (st.enable && heat) begin
                        next_st.state = ST_HEAT;
                    end
                end
                ST_COOL: begin
                    if (!cool || !st.enable) begin
                        next_st.state = ST_IDLE;
                    end
                end
                ST_HEAT: begin
                    if (!heat || cool || !st.enable) begin
                        next_st.state = ST_IDLE;
                    end else if (fd_req) begin
                        next_st.state       = ST_DEFROST;
                        next_st.forced      = 1'b1;
                        next_st.forced_open = !frost;
                        next_st.def_cnt     = '0;
                    end else if (tick && !ft_req) begin
                        if (st.run_cnt + 1'b1 >= run_target) begin
                            next_st.run_cnt = '0;
                            if (frost) begin
                                next_st.state   = ST_DEFROST;
                                next_st.def_cnt = '0;
                            end
                        end else begin
                            next_st.run_cnt = st.run_cnt + 1'b1;
                        end
                    end
                end
                ST_DEFROST: begin
                    if (!heat || !st.enable) begin
                        // demand gone: abandon defrost, forced request dies with it
                        next_st.state       = ST_IDLE;
                        next_st.forced      = 1'b0;
                        next_st.forced_open = 1'b0;
                    end else if (def_end) begin
                        next_st.state       = ST_HEAT;
                        next_st.run_cnt     = '0;
                        next_st.scaled      = 1'b0;
                        next_st.forced      = 1'b0;
                        next_st.forced_open = 1'b0;
                    end else if (tick) begin
                        next_st.def_cnt = st.def_cnt + 1'b1;
                    end
                end
                default: begin
                    next_st.state = ST_IDLE;
                end
            endcase
            // a fresh factory short wins over the clear at defrost end
            if (ft_req) begin
                next_st.scaled  = 1'b1;
                next_st.run_cnt = '0;
            end

            // valves follow the last mode that started
            if (next_st.state == ST_COOL) begin
                next_st.rv1 = 1'b1;
                next_st.rv2 = 1'b1;
            end else if (next_st.state == ST_HEAT && st.state == ST_IDLE) begin
                next_st.rv1 = 1'b0;
                next_st.rv2 = 1'b0;
            end
            next_st.comp1 = (next_st.state != ST_IDLE);
            next_st.comp2 = (next_st.state == ST_HEAT)
                            || (next_st.state == ST_DEFROST);

            // indoor fan with optional off delay
            if (next_st.state != ST_IDLE) begin
                next_st.fan     = 1'b1;
                next_st.fan_cnt = '0;
            end else if (st.state != ST_IDLE) begin
                next_st.fan     = !fan_sel;
                next_st.fan_cnt = '0;
            end else if (st.fan && tick) begin
                if (st.fan_cnt + 1'b1 >= CNT_W'(FAN_TICKS)) begin
                    next_st.fan = 1'b0;
                end else begin
                    next_st.fan_cnt = st.fan_cnt + 1'b1;
                end
            end

            // bus data phase: write lands here
            next_st.wr_pend = 1'b0;
            if (st.wr_pend && st.wr_addr == REG_CTRL) begin
                next_st.enable = hwdata[CTRL_EN_BIT];
            end
            // bus address phase: decode, read data registered for next cycle
            if (hsel && hready && htrans == HTRANS_NONSEQ) begin
                next_st.wr_pend = hwrite;
                next_st.wr_addr = haddr[7:0];
                if (!hwrite) begin
                    case (haddr[7:0])
                        REG_CTRL:   next_st.rdata = 32'(st.enable);
                        REG_STATUS: next_st.rdata = status_word;
                        REG_RUNCNT: next_st.rdata = 32'(st.run_cnt);
                        REG_DEFCNT: next_st.rdata = 32'(st.def_cnt);
                        default:    next_st.rdata = 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st        <= '0;
            st.state  <= ST_IDLE;
            st.enable <= CTRL_EN_RESET;
            st.ready  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // every output straight from the state register
    assign hrdata              = st.rdata;
    assign hreadyout           = st.ready;
    assign hresp               = st.resp;
    assign reversing_valve_one = st.rv1;
    assign reversing_valve_two = st.rv2;
    assign comp_one_cmd        = st.comp1;
    assign comp_two_cmd        = st.comp2;
    assign indoor_fan_cmd      = st.fan;

    // checks
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    valve_cool_a: assert property (st.state == ST_COOL |-> st.rv1 && st.rv2)
        else $error("valves not energised in cooling");
    valve_heat_a: assert property ($rose(st.state == ST_HEAT) && $past(st.state) == ST_IDLE
        |-> !st.rv1 && !st.rv2 ##1 (st.state != ST_HEAT || !st.rv1))
        else $error("valves energised in heating");

    // compressor count follows the running mode
    comp_mode_a: assert property (st.state == ST_HEAT |-> st.comp1 && st.comp2)
        else $error("compressors not both on in heating");
    comp_cool_a: assert property (st.state == ST_COOL |-> st.comp1 && !st.comp2)
        else $error("more than one compressor in cooling");

    // run count and valve memory across stops
    run_hold_a: assert property (st.state == ST_IDLE && $past(st.state) == ST_IDLE
        && !$past(ft_req) |-> $stable(st.run_cnt))
        else $error("run count moved while stopped");
    run_resume_a: assert property ($past(st.state) == ST_IDLE && st.state == ST_HEAT
        && !$past(ft_req) |-> $stable(st.run_cnt))
        else $error("held run count lost on heat restart");
    rv_hold_a: assert property ($past(st.state) != ST_IDLE && st.state != ST_COOL
        |-> $stable(st.rv1) && $stable(st.rv2))
        else $error("valves moved without a new mode");

    // defrost entry and length
    no_early_a: assert property ($rose(st.state == ST_DEFROST) && !st.forced
        |-> $past(st.run_cnt) + 1'b1 >= $past(run_target))
        else $error("defrost started inside run period");
    defrost_limit_a: assert property (st.state == ST_DEFROST |-> st.def_cnt < def_limit)
        else $error("defrost ran past its limit");
    forced_open_a: assert property ($past(st.state) == ST_DEFROST && $past(st.forced_open)
        && st.state == ST_HEAT |-> $past(st.def_cnt) == CNT_W'(FORCED_TICKS - 1))
        else $error("forced open defrost not 30 s");
    forced_entry_a: assert property ($rose(st.state == ST_DEFROST) && st.forced
        |-> $past(fd_req) && $past(st.state) == ST_HEAT)
        else $error("forced defrost without an in-window short");
    mode_end_a: assert property ($past(st.state) == ST_DEFROST && st.state == ST_HEAT
        && !$past(ft_req) |-> !st.scaled && !st.forced && st.run_cnt == '0)
        else $error("speed-up mode survived defrost");
    ft_bound_a: assert property (st.scaled && !st.forced_open
        |-> def_limit <= CNT_W'(FT_DEF_MAX_TICKS))
        else $error("factory test defrost over 12 s");
    fan_delay_a: assert property ($fell(st.comp1) && st.fan |-> !$past(fan_sel))
        else $error("fan delay while disabled");
endmodule : hpd_defrost_board

// >>> hdl/hpd_pkg.sv
// shared constants and types for the heat pump defrost timer
package hpd_pkg;
    // clock and timebase: one tick is a tenth of a second
    localparam int unsigned CLK_PERIOD_NS   = 32'h0000_000A; // 10 ns
    localparam int unsigned TICK_PERIOD_NS  = 32'h05F5_E100; // 100 ms
    localparam int unsigned NS_PER_SEC      = 32'h3B9A_CA00;
    localparam int unsigned TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned TICKS_PER_SEC   = NS_PER_SEC / TICK_PERIOD_NS;
    localparam int unsigned SEC_PER_MIN     = 32'h0000_003C;
    localparam int unsigned TICKS_PER_MIN   = SEC_PER_MIN * TICKS_PER_SEC;
    // scaled mode: 0.1 s (100 ms) stands for one minute
    localparam int unsigned SCALED_NS_PER_MIN = 32'h05F5_E100;
    localparam int unsigned SCALED_TPM      = SCALED_NS_PER_MIN / TICK_PERIOD_NS;

    // counter width, enough for 120 minutes of ticks
    localparam int unsigned CNT_W           = 32'h0000_0012;

    // run period choices in minutes
    localparam int unsigned RUN_MIN_0       = 32'h0000_001E; // 30
    localparam int unsigned RUN_MIN_1       = 32'h0000_003C; // 60, default
    localparam int unsigned RUN_MIN_2       = 32'h0000_005A; // 90
    localparam int unsigned RUN_MIN_3       = 32'h0000_0078; // 120

    // defrost, forced defrost and fan delay times
    localparam int unsigned DEFROST_MIN     = 32'h0000_000A; // 10 min
    localparam int unsigned FORCED_OPEN_S   = 32'h0000_001E; // 30 s
    localparam int unsigned FAN_DELAY_S     = 32'h0000_001E; // 30 s
    localparam int unsigned FT_DEF_MAX_S    = 32'h0000_000C; // 12 s
    localparam int unsigned FORCED_TICKS    = FORCED_OPEN_S * TICKS_PER_SEC;
    localparam int unsigned FAN_TICKS       = FAN_DELAY_S * TICKS_PER_SEC;
    localparam int unsigned FT_DEF_MAX_TICKS = FT_DEF_MAX_S * TICKS_PER_SEC;

    // speed-up short windows in seconds
    localparam int unsigned FT_MIN_S        = 32'h0000_0001;
    localparam int unsigned FT_MAX_S        = 32'h0000_0003;
    localparam int unsigned FD_MIN_S        = 32'h0000_0005;
    localparam int unsigned FD_MAX_S        = 32'h0000_0014;
    localparam int unsigned SHORT_W         = 32'h0000_0008;

    // register map, byte addresses
    localparam logic [7:0]  REG_CTRL        = 8'h00;
    localparam logic [7:0]  REG_STATUS      = 8'h04;
    localparam logic [7:0]  REG_RUNCNT      = 8'h08;
    localparam logic [7:0]  REG_DEFCNT      = 8'h0C;
    localparam int unsigned CTRL_EN_BIT     = 32'h0000_0000;
    localparam logic        CTRL_EN_RESET   = 1'h1;

    // bus encodings
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

    // controller states
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_HEAT    = 4'h2,
        ST_DEFROST = 4'h4,
        ST_COOL    = 4'h8
    } hpd_state_type;
endpackage : hpd_pkg

// >>> hdl/hpd_sync.sv
// two-flop synchroniser for the switch and demand inputs
module hpd_sync #(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             ce,
    // raw and synchronised levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    import hpd_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } hpd_sync_type;

    hpd_sync_type st;
    hpd_sync_type next_st;

    // first stage only feeds the second
    always_comb begin
        next_st = st;
        if (ce) begin
            next_st.first  = async_in;
            next_st.second = st.first;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.second;
endmodule : hpd_sync

// >>> hdl/hpd_tick.sv
// tenth-second timebase divider
module hpd_tick #(
    parameter int unsigned CYCLES = 10
) (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    // one-cycle pulse every CYCLES enabled cycles
    output logic      tick
);
    import hpd_pkg::*;

    localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } hpd_tick_type;

    hpd_tick_type st;
    hpd_tick_type next_st;

    // wrap counter, pulse on the wrap
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (ce) begin
            if (st.cnt == LAST) begin
                next_st.cnt  = '0;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule : hpd_tick

// >>> testbench/hpd_tstat_model.sv
// thermostat and coil frost switch model for the defrost board bench
module hpd_tstat_model (
    // bench clock
    input  wire logic hclk,
    // demands and frost switch
    output logic      cool_call_stage1,
    output logic      heat_call_stage1,
    output logic      coil_frost_switch
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle thermostat and a warm coil at power-up
    initial begin
        cool_call_stage1  = 1'h0;
        heat_call_stage1  = 1'h0;
        coil_frost_switch = 1'h0;
    end
    // contacts move just after an edge, never on it
    task drive(input logic c, input logic h, input logic f);
        @(posedge hclk);
        cool_call_stage1  <= c;
        heat_call_stage1  <= h;
        coil_frost_switch <= f;
    endtask : drive
endmodule : hpd_tstat_model

// >>> testbench/tb.sv
// self-checking bench for the defrost board controller
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import hpd_pkg::*;
    localparam int unsigned TC = 4;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, seen;
    logic [1:0]  htrans, look;
    logic        cool, heat, frost, rps_lo, rps_hi, fan_sel, jmp_a, jmp_b;
    logic        rv1, rv2, c1, c2, fan;
    logic [31:0] exp_q[$], msk_q[$];
    int          miscompares, checks_done;
    assign hready = hreadyout;
    hpd_tstat_model tstat (.hclk(hclk), .cool_call_stage1(cool),
        .heat_call_stage1(heat), .coil_frost_switch(frost));
    hpd_defrost_board #(.TICK_CYC(TC)) uut (.hclk(hclk), .hresetn(hresetn), .ce(1'h1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cool_call_stage1(cool), .heat_call_stage1(heat),
        .coil_frost_switch(frost), .run_period_select_lo(rps_lo),
        .run_period_select_hi(rps_hi), .fan_delay_select(fan_sel),
        .speedup_contact_a(jmp_a), .speedup_contact_b(jmp_b),
        .reversing_valve_one(rv1), .reversing_valve_two(rv2), .comp_one_cmd(c1),
        .comp_two_cmd(c2), .indoor_fan_cmd(fan));
    // free-running 100 MHz clock
    initial begin
        hclk = 1'h0;
        forever #5 hclk = ~hclk;
    end
    // verdict, printed once from here only
    task wrap_up();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task check(input logic [31:0] got, input logic [31:0] want);
        checks_done++;
        if (got !== want) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, want);
        end
    endtask : check
    // single ahb-lite transfer; a read leaves its note for the monitor
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
             input logic [31:0] m, input logic [31:0] e);
        @(posedge hclk);
        hsel   <= 1'h1;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        htrans <= 2'h0;
        hsel   <= 1'h0;
        hwdata <= d;
        if (!wr) begin
            look <= 2'h1;
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        @(posedge hclk);
        while (hready !== 1'h1) @(posedge hclk);
        look <= 2'h0;
    endtask : bus
    // note the expected driver outputs {rv1,rv2,c1,c2,fan}
    task pins(input logic [4:0] e);
        @(posedge hclk);
        look <= 2'h2;
        exp_q.push_back({27'h0, e});
        msk_q.push_back(32'h0000_001F);
        @(posedge hclk);
        look <= 2'h0;
    endtask : pins
    task ticks(input int n);
        repeat (n * TC) @(posedge hclk);
    endtask : ticks
    // jumper short held for n ticks, then opened
    task short(input int n);
        @(posedge hclk);
        jmp_a <= 1'h1;
        jmp_b <= 1'h1;
        ticks(n);
        jmp_a <= 1'h0;
        jmp_b <= 1'h0;
    endtask : short
    // monitor: oldest note against what the design shows now
    always @(posedge hclk) begin
        if (look == 2'h2 || (look == 2'h1 && hready === 1'h1)) begin
            seen = (look == 2'h1) ? hrdata : {27'h0, rv1, rv2, c1, c2, fan};
            check(seen & msk_q.pop_front(), exp_q.pop_front());
            if (look == 2'h1) begin
                check(32'(hresp), 32'h0000_0000);
            end
        end
    end
    // watchdog, generous against about 4000 cycles of tests
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        wrap_up();
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata, look} = '0;
        {rps_lo, rps_hi, fan_sel, jmp_a, jmp_b} = '0;
        void'($urandom(13552));
        repeat (12) @(posedge hclk);
        hresetn <= 1'h1;
        pins(5'h00);
        bus(1'h1, REG_CTRL, {31'($urandom), 1'h1}, 0, 0);
        bus(1'h0, REG_CTRL, 0, 32'h0000_0001, 32'h0000_0001);
        bus(1'h0, 8'h40, 0, 32'hFFFF_FFFF, 32'h0000_0000);
        $display("test bus done");
        tstat.drive(1'h1, 1'h0, 1'h0);
        ticks(2);
        pins(5'h1D);
        tstat.drive(1'h0, 1'h0, 1'h0);
        ticks(290);
        pins(5'h19);
        ticks(20);
        pins(5'h18);
        $display("test cool done");
        fan_sel <= 1'h1;
        tstat.drive(1'h0, 1'h1, 1'h0);
        ticks(2);
        pins(5'h07);
        short(50 + $urandom % 151);
        ticks(5);
        bus(1'h0, REG_STATUS, 0, 32'h0000_1E80, 32'h0000_0880);
        ticks(280);
        bus(1'h0, REG_STATUS, 0, 32'h0000_1E80, 32'h0000_0880);
        ticks(20);
        bus(1'h0, REG_STATUS, 0, 32'h0000_1E80, 32'h0000_0400);
        $display("test forced done");
        short(10 + $urandom % 21);
        ticks(35);
        bus(1'h0, REG_STATUS, 0, 32'h0000_1F00, 32'h0000_0500);
        tstat.drive(1'h0, 1'h1, 1'h1);
        ticks(28);
        bus(1'h0, REG_STATUS, 0, 32'h0000_1F00, 32'h0000_0900);
        ticks(17);
        bus(1'h0, REG_STATUS, 0, 32'h0000_1F00, 32'h0000_0400);
        $display("test scaled done");
        tstat.drive(1'h0, 1'h0, 1'h1);
        ticks(2);
        pins(5'h00);
        rps_lo <= 1'h1;
        tstat.drive(1'h0, 1'h1, 1'h1);
        short(10 + $urandom % 21);
        ticks(45);
        bus(1'h0, REG_STATUS, 0, 32'h0000_1F00, 32'h0000_0500);
        ticks(20);
        bus(1'h0, REG_STATUS, 0, 32'h0000_1F00, 32'h0000_0900);
        $display("test period done");
        tstat.drive(1'h0, 1'h0, 1'h0);
        ticks(2);
        wrap_up();
    end
endmodule : tb
